// *** shared/cms_pkg.sv ***
// shared constants and types for the core memory bus slave
package cms_pkg;

	// data path and address widths
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int WORDS_SMALL = 4096;
	localparam int WORDS_LARGE = 8192;

	// timing figures in ns and the clock they are counted in
	localparam int CLK_PERIOD_NS = 20;
	localparam int T_CYCLE_NS = 900;
	localparam int T_HALF_NS = 450;
	localparam int T_ACCESS_NS = 400;
	localparam int T_WACCEPT_NS = 200;

	// cycle counts: these are longest times, so they round down
	typedef logic [5:0] cms_cnt_t;
	localparam cms_cnt_t CYC_CNT = cms_cnt_t'(T_CYCLE_NS / CLK_PERIOD_NS);
	localparam cms_cnt_t HALF_CNT = cms_cnt_t'(T_HALF_NS / CLK_PERIOD_NS);
	localparam cms_cnt_t ACC_CNT = cms_cnt_t'(T_ACCESS_NS / CLK_PERIOD_NS);
	localparam cms_cnt_t WACC_CNT = cms_cnt_t'(T_WACCEPT_NS / CLK_PERIOD_NS);

	// points in the cycle counter, counted from the cycle start (count 0)
	localparam cms_cnt_t SENSE_PT = WACC_CNT - 6'h02;
	localparam cms_cnt_t ACK_RD_PT = ACC_CNT - 6'h01;
	localparam cms_cnt_t ACK_WR_PT = WACC_CNT - 6'h01;
	localparam cms_cnt_t ACK_WR_SKIP_PT = HALF_CNT + WACC_CNT - 6'h01;
	localparam cms_cnt_t END_HALF_PT = HALF_CNT - 6'h01;
	localparam cms_cnt_t END_FULL_PT = CYC_CNT - 6'h01;

	// register map (byte addresses) and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_COUNT = 8'h08;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_BANK_LSB = 4;
	localparam int BANK_W = 5;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [4:0] CTRL_BANK_RST = 5'h00;
	localparam int STAT_PAUSE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_SUPPLY_BIT = 2;
	localparam int STAT_CYC_LSB = 4;

	// cycle kinds in the order of the two type lines, high line first
	typedef enum logic [1:0] {
		read_restore_cycle,
		read_pause_cycle,
		word_write_cycle,
		byte_write_cycle
	} cms_cyc_e;

	// sequencer states
	typedef enum logic [1:0] {
		st_idle,
		st_run,
		st_release
	} cms_state_e;

	// everything the bus master drives towards the memory
	typedef struct packed {
		logic req;
		logic cycle_type_high;
		logic cycle_type_low;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cms_bus_req_s;

endpackage

// *** verilog/cms_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
`default_nettype none
module cms_pin_sync #(
	parameter int W = 1
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] d,
	output var logic [W-1:0] q
);
	generate
		if (W < 1) begin : g_bad_width
			$error("cms_pin_sync needs at least one bit");
		end
	endgenerate

	// per-bit lane: first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					s1_ff <= d[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					// a change counts only once two stages agree
					if (s2_ff == s3_ff) begin
						q[i] <= s3_ff;
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** verilog/cms_core_slave.sv ***
// core memory bank slave: bus cycle sequencer, data register, ahb-lite status port
//
// Overview of operation
// - words are 16 bits, 4096 or 8192
// - read data by 400 ns, cycle 900 ns
// - unpaused write: 900 ns, data taken 200 ns
// - cycle kind chosen from two type lines
// - byte select line picks written byte
// - acknowledge request, run timing, move data
// - latch 18-bit address, decode bank and word
// - bank decoder gates response to own bank
// - data register keeps destructively read word
// - writes load bus data into register
// - sensed ones set register bits, cores cleared
// - inhibit every bit written as zero
// - separate read and write drive polarity
// - supply low warning blocks memory operations
// - type codes: 00,01,10,11 high line first
// - read pause skips restore, sets pause flag
// - paused write skips read, half duration
// - byte write restores the unselected byte
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cms_core_slave #(
	parameter int WORDS = cms_pkg::WORDS_LARGE
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire cms_pkg::cms_bus_req_s bus_in,
	input wire logic supply_low_warning,
	output logic slave_ack,
	output logic [cms_pkg::DATA_W-1:0] bus_data_out,
	output logic bus_data_oe,
	output logic [cms_pkg::DATA_W-1:0] inhibit,
	output logic read_drive,
	output logic write_drive
);
	import cms_pkg::*;

	localparam int AW = $clog2(WORDS);
	localparam int BW = ADDR_W - 1 - AW;

	// only the two documented bank sizes are built
	generate
		if (WORDS != WORDS_SMALL && WORDS != WORDS_LARGE) begin : g_bad_words
			$error("cms_core_slave: WORDS must be 4096 or 8192");
		end
	endgenerate

	// pins from the asynchronous bus, filtered
	cms_bus_req_s bus_s;
	logic supply_low_s;
	logic [$bits(cms_bus_req_s):0] sync_q;

	cms_pin_sync #(
		.W($bits(cms_bus_req_s) + 1)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({supply_low_warning, bus_in}),
		.q(sync_q)
	);

	assign bus_s = cms_bus_req_s'(sync_q[$bits(cms_bus_req_s)-1:0]);
	assign supply_low_s = sync_q[$bits(cms_bus_req_s)];

	// control and status state
	cms_state_e state_ff;
	cms_state_e nxt_state;
	cms_cyc_e cyc_ff;
	cms_cnt_t cnt_ff;
	logic [AW-1:0] word_ff;
	logic [AW-1:0] pause_word_ff;
	logic byte_sel_ff;
	logic skip_ff;
	logic pause_ff;
	logic [DATA_W-1:0] data_reg_ff;
	logic ctrl_en_ff;
	logic [BANK_W-1:0] bank_ff;
	logic [15:0] count_ff;
	logic ack_ff;
	logic [DATA_W-1:0] data_out_ff;
	logic data_oe_ff;
	logic [DATA_W-1:0] inhibit_ff;
	logic read_drive_ff;
	logic write_drive_ff;

	// the core stack itself: cores hold their state, so no reset
	logic [DATA_W-1:0] core_mem [WORDS];

	// address and cycle decode of the incoming request
	cms_cyc_e req_cyc;
	logic [AW-1:0] req_word;
	logic bank_hit;
	logic req_is_write;
	logic req_skip;
	logic start;
	assign req_cyc = cms_cyc_e'({bus_s.cycle_type_high, bus_s.cycle_type_low});
	assign req_word = bus_s.addr[AW:1];
	assign bank_hit = bus_s.addr[ADDR_W-1:AW+1] == bank_ff[BW-1:0];
	assign req_is_write = req_cyc == word_write_cycle || req_cyc == byte_write_cycle;
	assign req_skip = req_is_write && pause_ff && req_word == pause_word_ff;
	// a low supply keeps new cycles from starting at all
	assign start = state_ff == st_idle && bus_s.req && bank_hit && ctrl_en_ff
		&& !supply_low_s;

	// timing points of the running cycle
	logic running;
	logic is_write;
	logic is_read;
	cms_cnt_t ack_pt;
	cms_cnt_t end_pt;
	logic at_sense;
	logic at_ack;
	logic at_end;
	logic in_write_phase;
	assign running = state_ff == st_run;
	assign is_write = cyc_ff == word_write_cycle || cyc_ff == byte_write_cycle;
	assign is_read = !is_write;
	assign ack_pt = is_read ? ACK_RD_PT : (skip_ff ? ACK_WR_SKIP_PT : ACK_WR_PT);
	assign end_pt = cyc_ff == read_pause_cycle ? END_HALF_PT : END_FULL_PT;
	assign at_sense = running && !skip_ff && cnt_ff == SENSE_PT;
	assign at_ack = running && cnt_ff == ack_pt;
	assign at_end = running && cnt_ff == end_pt;
	assign in_write_phase = running && cnt_ff >= HALF_CNT && cyc_ff != read_pause_cycle;

	// core access strobes, both dropped while supply is low
	logic mem_clear;
	logic mem_store;
	logic [DATA_W-1:0] core_word;
	assign mem_clear = at_sense && !supply_low_s;
	assign mem_store = at_end && cyc_ff != read_pause_cycle && !supply_low_s;
	assign core_word = core_mem[word_ff];

	// bus data merged with the kept byte for byte writes
	logic [DATA_W-1:0] merged;
	logic [DATA_W-1:0] byte_merge;
	assign byte_merge = byte_sel_ff ? {bus_s.data[15:8], data_reg_ff[7:0]}
		: {data_reg_ff[15:8], bus_s.data[7:0]};
	assign merged = cyc_ff == byte_write_cycle ? byte_merge : bus_s.data;

	// destructive read clears the word, write phase stores the register
	always_ff @(posedge hclk) begin
		if (mem_clear) begin
			core_mem[word_ff] <= '0;
		end else if (mem_store) begin
			core_mem[word_ff] <= data_reg_ff;
		end
	end

	// sequencer: idle, run the timed cycle, then wait for request release
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			st_idle: begin
				if (start) begin
					nxt_state = st_run;
				end
			end
			st_run: begin
				// a supply failure abandons the cycle without touching the cores
				if (supply_low_s) begin
					nxt_state = st_idle;
				end else if (at_end) begin
					// only a request still acknowledged is the old one; a fresh
					// request raised during the restore starts the next cycle
					nxt_state = ack_ff ? st_release : st_idle;
				end
			end
			st_release: begin
				if (!bus_s.req) begin
					nxt_state = st_idle;
				end
			end
			default: begin
				nxt_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= st_idle;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// request capture and cycle counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_ff <= read_restore_cycle;
			word_ff <= '0;
			byte_sel_ff <= 1'b0;
			skip_ff <= 1'b0;
			cnt_ff <= '0;
		end else if (start) begin
			cyc_ff <= req_cyc;
			word_ff <= req_word;
			byte_sel_ff <= bus_s.addr[0];
			skip_ff <= req_skip;
			// a paused write enters straight at the write phase
			cnt_ff <= req_skip ? HALF_CNT : 6'h00;
		end else if (running) begin
			cnt_ff <= cnt_ff + 6'h01;
		end
	end

	// data register: sensed word first, bus data at the accept point
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_reg_ff <= '0;
		end else if (at_sense) begin
			data_reg_ff <= core_word;
		end else if (at_ack && is_write) begin
			data_reg_ff <= merged;
		end
	end

	// pause flag: set by a finished read pause, consumed by a later write to the same word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pause_ff <= 1'b0;
			pause_word_ff <= '0;
		end else if (at_end && !supply_low_s) begin
			if (cyc_ff == read_pause_cycle) begin
				pause_ff <= 1'b1;
				pause_word_ff <= word_ff;
			end else if (is_write && skip_ff) begin
				pause_ff <= 1'b0;
			end
		end
	end

	// interlocked acknowledge: held until the master drops its request or supply goes low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_ff <= 1'b0;
		end else if (!bus_s.req || supply_low_s) begin
			ack_ff <= 1'b0;
		end else if (at_ack) begin
			ack_ff <= 1'b1;
		end
	end

	// read data onto the bus with the acknowledge, released at cycle end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_out_ff <= '0;
			data_oe_ff <= 1'b0;
		end else if (at_end || !running) begin
			data_oe_ff <= 1'b0;
		end else if (at_ack && is_read) begin
			data_out_ff <= data_reg_ff;
			data_oe_ff <= 1'b1;
		end
	end

	// drive switches and inhibit drivers follow the cycle phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			read_drive_ff <= 1'b0;
			write_drive_ff <= 1'b0;
			inhibit_ff <= '0;
		end else begin
			read_drive_ff <= running && !skip_ff && cnt_ff < HALF_CNT && !supply_low_s;
			write_drive_ff <= in_write_phase && !supply_low_s;
			// zeros are written by cancelling the drive on that bit's mat
			inhibit_ff <= (in_write_phase && !supply_low_s) ? ~data_reg_ff : '0;
		end
	end

	// completed cycles, a cheap activity monitor for software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff <= '0;
		end else if (at_end && !supply_low_s) begin
			count_ff <= count_ff + 16'h0001;
		end
	end

	// ahb-lite slave: zero wait state, read data captured at the address phase
	logic ap_valid;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] rd_val;
	logic [31:0] ctrl_val;
	logic [31:0] status_val;
	assign ap_valid = hsel && hready && htrans[1];
	assign ctrl_val = (32'(bank_ff) << CTRL_BANK_LSB) | (32'(ctrl_en_ff) << CTRL_EN_BIT);
	assign status_val = (32'(pause_ff) << STAT_PAUSE_BIT)
		| (32'(state_ff != st_idle) << STAT_BUSY_BIT)
		| (32'(supply_low_s) << STAT_SUPPLY_BIT)
		| (32'(cyc_ff) << STAT_CYC_LSB);
	// unmapped offsets read as zero and still answer okay
	assign rd_val = haddr[7:0] == REG_CTRL ? ctrl_val
		: haddr[7:0] == REG_STATUS ? status_val
		: haddr[7:0] == REG_COUNT ? {16'h0000, count_ff} : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
			hrdata_ff <= '0;
		end else begin
			wr_pend_ff <= ap_valid && hwrite;
			wr_addr_ff <= haddr[7:0];
			if (ap_valid && !hwrite) begin
				hrdata_ff <= rd_val;
			end
		end
	end

	// control register: enable and bank number, written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_en_ff <= CTRL_EN_RST;
			bank_ff <= CTRL_BANK_RST;
		end else if (wr_pend_ff && wr_addr_ff == REG_CTRL) begin
			ctrl_en_ff <= hwdata[CTRL_EN_BIT];
			bank_ff <= hwdata[CTRL_BANK_LSB +: BANK_W];
		end
	end

	// hsize is not checked: only whole words are ever issued
	logic unused_ok;
	assign unused_ok = ^{hsize, haddr[31:8]};

	assign hrdata = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign slave_ack = ack_ff;
	assign bus_data_out = data_out_ff;
	assign bus_data_oe = data_oe_ff;
	assign inhibit = inhibit_ff;
	assign read_drive = read_drive_ff;
	assign write_drive = write_drive_ff;
endmodule
`default_nettype wire

// *** dv/cms_core_slave_properties.sv ***
// checker of the memory bus timing of the core slave
`timescale 1ns/1ps
`default_nettype none
module cms_core_slave_props #(
	parameter int WORDS = 8192
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire cms_pkg::cms_bus_req_s bus_in,
	input wire logic supply_low_warning,
	input wire logic slave_ack,
	input wire logic bus_data_oe,
	input wire logic [cms_pkg::DATA_W-1:0] inhibit,
	input wire logic read_drive,
	input wire logic write_drive
);
	import cms_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// drive switches and inhibit
	AST_DRV_EXCL: assert property (!(read_drive && write_drive))
		else $error("read and write drive together");
	AST_INH_WR: assert property (|inhibit |-> write_drive)
		else $error("inhibit outside write phase");
	AST_RD_LEN: assert property ($rose(read_drive) |-> read_drive[*8] ##[13:16] !read_drive)
		else $error("read phase length wrong");
	// acknowledge timing per cycle kind
	AST_ACK_RD: assert property (
		$rose(read_drive) && !bus_in.cycle_type_high |-> ##[1:20] $rose(slave_ack))
		else $error("read ack late");
	AST_ACK_WR: assert property (
		$rose(read_drive) && bus_in.cycle_type_high |-> ##[1:10] $rose(slave_ack))
		else $error("write ack late");
	AST_ACK_REQ: assert property (!bus_in.req[*8] |-> !slave_ack)
		else $error("ack without request");
	// data lines only on reads, released by cycle end
	AST_OE_READ: assert property ($rose(bus_data_oe) |-> slave_ack && !bus_in.cycle_type_high)
		else $error("data driven outside read");
	AST_OE_REL: assert property ($rose(bus_data_oe) |-> ##[1:30] !bus_data_oe)
		else $error("data lines not released");
	// supply low stops everything
	AST_SUPPLY: assert property (
		supply_low_warning[*8] |-> !slave_ack && !read_drive && !write_drive)
		else $error("activity during supply low");
endmodule
bind cms_core_slave cms_core_slave_props #(.WORDS(WORDS)) u_props (
	.hclk(hclk),
	.hresetn(hresetn),
	.bus_in(bus_in),
	.supply_low_warning(supply_low_warning),
	.slave_ack(slave_ack),
	.bus_data_oe(bus_data_oe),
	.inhibit(inhibit),
	.read_drive(read_drive),
	.write_drive(write_drive)
);
`default_nettype wire

// *** dv/cms_master_model.sv ***
// bus master model running memory cycles on the request lines
`timescale 1ns/1ps
`default_nettype none
module cms_master_model (
	input wire logic hclk,
	input wire logic slave_ack,
	input wire logic bus_data_oe,
	input wire logic [cms_pkg::DATA_W-1:0] bus_data_out,
	output var cms_pkg::cms_bus_req_s bus_in
);
	import cms_pkg::*;
	// lines start idle
	initial begin
		bus_in = '0;
	end
	// one interlocked cycle: request, wait ack, release, wait ack drop
	task automatic xfer(input logic [1:0] t, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic ok,
		output logic oe);
		int n;
		n = 0;
		@(posedge hclk);
		bus_in <= {1'b1, t[1], t[0], a, d};
		do begin
			@(posedge hclk);
			n++;
		end while (slave_ack !== 1'b1 && n < 120);
		ok = slave_ack;
		q = bus_data_out;
		oe = bus_data_oe;
		// released lines show the inverse so stale values cannot pass
		bus_in <= {1'b0, ~t[1], ~t[0], ~a, ~d};
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (slave_ack !== 1'b0 && n < 20);
	endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// testbench for the core memory bus slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cms_pkg::*;
	logic hclk, hresetn, hsel, hwrite, supply_low_warning, ok, oe, rd_prev;
	logic [31:0] haddr, hwdata, r;
	logic [1:0] htrans;
	logic [DATA_W-1:0] q, inh_seen;
	wire [31:0] hrdata;
	wire hreadyout, hresp, slave_ack, bus_data_oe, read_drive, write_drive;
	wire [DATA_W-1:0] bus_data_out, inhibit;
	wire cms_bus_req_s bus_in;
	int error_cnt, cmp_count, cyc, rdr, rdr0;
	localparam logic [ADDR_W-1:0] A1 = {4'h2, 13'h0005, 1'b0};
	localparam logic [ADDR_W-1:0] A2 = {4'h2, 13'h1fff, 1'b0};
	localparam logic [ADDR_W-1:0] A3 = {4'h3, 13'h0005, 1'b0};
	cms_core_slave DUT (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hsize(3'h2),
		.hwrite(hwrite),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.bus_in(bus_in),
		.supply_low_warning(supply_low_warning),
		.slave_ack(slave_ack),
		.bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe),
		.inhibit(inhibit),
		.read_drive(read_drive),
		.write_drive(write_drive)
	);
	cms_master_model mdl (
		.hclk(hclk),
		.slave_ack(slave_ack),
		.bus_data_oe(bus_data_oe),
		.bus_data_out(bus_data_out),
		.bus_in(bus_in)
	);
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// watch read phases, last inhibit pattern, and a hang
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		rd_prev <= read_drive;
		if (read_drive === 1'b1 && rd_prev !== 1'b1) rdr <= rdr + 1;
		if (write_drive === 1'b1) inh_seen <= inhibit;
		if (cyc == 30000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// single ahb-lite transfer, address phase then data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		r = hrdata;
	endtask
	task automatic mx(input logic [1:0] t, input logic [ADDR_W-1:0] a, input logic [15:0] d);
		mdl.xfer(t, a, d, q, ok, oe);
	endtask
	// poll busy so the pause flag is read after the cycle ends
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			ahb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 60);
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = '0;
		supply_low_warning = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, REG_CTRL, 32'h0);
		chk(r, 32'h1);
		chk(hresp, 32'h0);
		ahb(1'b1, 8'h0c, 32'hffffffff);
		ahb(1'b0, 8'h0c, 32'h0);
		chk(r, 32'h0);
		ahb(1'b1, REG_CTRL, 32'h21);
		// word write, then two reads restore it
		mx(2'b10, A1, 16'ha5c3);
		chk(ok, 1'b1);
		chk(oe, 1'b0);
		mx(2'b00, A1, 16'h0);
		chk(q, 16'ha5c3);
		chk(oe, 1'b1);
		chk(inh_seen, 16'h5a3c);
		mx(2'b00, A1, 16'h0);
		chk(q, 16'ha5c3);
		// byte writes keep the other byte
		mx(2'b11, A1 | 18'h1, 16'h7e11);
		mx(2'b00, A1, 16'h0);
		chk(q, 16'h7ec3);
		mx(2'b11, A1, 16'h0022);
		mx(2'b00, A1, 16'h0);
		chk(q, 16'h7e22);
		// top word of the bank
		mx(2'b10, A2, 16'hffff);
		mx(2'b00, A2, 16'h0);
		chk(q, 16'hffff);
		// read pause then paused write, no read phase in between
		mx(2'b01, A1, 16'h0);
		chk(q, 16'h7e22);
		ahb(1'b0, REG_STATUS, 32'h0);
		chk(r[STAT_PAUSE_BIT], 1'b1);
		rdr0 = rdr;
		mx(2'b10, A1, 16'h3c3c);
		chk(ok, 1'b1);
		chk(rdr, rdr0);
		wait_idle();
		chk(r[STAT_PAUSE_BIT], 1'b0);
		// eleven memory cycles have finished by now
		ahb(1'b0, REG_COUNT, 32'h0);
		chk(r, 32'h0000_000b);
		mx(2'b00, A1, 16'h0);
		chk(q, 16'h3c3c);
		// other bank and disabled bank stay silent
		mx(2'b00, A3, 16'h0);
		chk(ok, 1'b0);
		ahb(1'b1, REG_CTRL, 32'h20);
		mx(2'b00, A1, 16'h0);
		chk(ok, 1'b0);
		ahb(1'b1, REG_CTRL, 32'h21);
		// supply low blocks cycles and leaves data intact
		supply_low_warning <= 1'b1;
		repeat (8) @(posedge hclk);
		ahb(1'b0, REG_STATUS, 32'h0);
		chk(r[STAT_SUPPLY_BIT], 1'b1);
		mx(2'b10, A1, 16'hffff);
		chk(ok, 1'b0);
		supply_low_warning <= 1'b0;
		repeat (8) @(posedge hclk);
		mx(2'b00, A1, 16'h0);
		chk(q, 16'h3c3c);
		complete_run();
	end
endmodule
`default_nettype wire
